/* verilog/ffms_sequencer.sv */
`timescale 1ns/1ps
`include "ffms_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Fault and mode sequencer for a flyback controller. Supply lockout acts as
// the reset of the sequence; switching cycles pace the qualifiers, CORE_CLK cycles the two timers.
////////////////////////////////////////////////////////////////////////////////
module ffms_sequencer #(
	parameter int unsigned OVL_CYCLES   = `FFMS_OVL_CYC,  // Overload timeout count
	parameter int unsigned CSMIN_CYCLES = `FFMS_CSMIN_CYC // Sense minimum window
) (
	input  wire logic      CORE_CLK,
	input  wire logic      NRST,
	input  wire logic      VDD_ON,        // Supply above turn-on threshold
	input  wire logic      VDD_OFF,       // Supply below turn-off threshold
	input  wire logic      CYCLE_START,   // Pulse: control law starts a cycle
	input  wire logic      PEAK_REACHED,  // Pulse: current reached peak target
	input  wire logic      DEMAG_END,     // Pulse: demagnetization finished
	input  wire logic      BLANK_DONE,    // Level: leading-edge blanking over
	input  wire logic      OVP_CMP,       // Aux sense sample above threshold
	input  wire logic      LINE_RUN_CMP,  // Line current above run threshold
	input  wire logic      LINE_STOP_CMP, // Line current below stop threshold
	input  wire logic      OC_CMP,        // Sense above over-current level
	input  wire logic      CSMIN_CMP,     // Sense reached minimum check level
	input  wire logic      OTP_CMP,       // Junction over temperature
	input  wire logic      HS_OPEN,       // High-side divider open detected
	input  wire logic      CCL_ACTIVE,    // Output at constant-current limit
	input  wire logic      PEAK_AT_MAX,   // Peak current at ceiling
	output logic           GATE_DRIVE,    // Gate drive output
	output logic [1:0]     BIAS_SEL,      // Bias level select
	output logic           PEAK_SEL,      // Peak select: floor or control law
	output logic [2:0]     STATE,         // Sequencer state
	output logic [5:0]     FAULT_CAUSE    // Last fault cause
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////////////////
	ffms_pkg::ffms_state_t st_reg;        // Sequencer state
	ffms_pkg::ffms_state_t st_next;       // Next state
	logic                  drv_reg;       // Gate drive flop
	logic                  drv_next;      // Next gate drive
	logic [1:0]            start_cnt_reg; // Start-up cycles done
	logic [1:0]            start_cnt_next;
	logic                  first_reg;     // In first start-up cycle
	logic                  first_next;
	logic                  csmin_ok_reg;  // Sense minimum seen since start
	logic                  csmin_ok_next;
	logic [10:0]           csmin_cnt_reg; // Window timer
	logic [10:0]           csmin_cnt_next;
	logic                  line_ok_reg;   // Run threshold met since start
	logic                  line_ok_next;
	logic                  line_smp_reg;  // Line sample held from on-time
	logic                  line_smp_next;
	logic                  stop_smp_reg;  // Stop sample held from on-time
	logic                  stop_smp_next;
	logic                  oc_seen_reg;   // Over-current seen in window
	logic                  oc_seen_next;
	logic                  demag_reg;     // Demagnetizing phase
	logic                  demag_next;
	logic [24:0]           ovl_cnt_reg;   // Overload timer
	logic [24:0]           ovl_cnt_next;
	logic                  ovl_trip;      // Overload timeout reached
	logic                  hs_hold_reg;   // High-side open retry mode
	logic                  hs_hold_next;
	logic [5:0]            cause_reg;     // Latched fault cause
	logic [5:0]            cause_next;
	ffms_pkg::ffms_cmp_t   cmp;           // Per-cycle comparator bundle
	ffms_pkg::ffms_cause_t cause_now;     // Faults detected this cycle
	logic [2:0]            hits;          // Qualified counter outputs
	logic                  clr_cnt;       // Counter clear on start entry
	logic                  cyc_end;       // End of a switching cycle
	logic                  fault_any;     // Any fault this cycle
	logic                  csmin_fail;    // Window expired without minimum

	// Counters clear whenever sequencer sits in start
	assign clr_cnt = (st_reg == ffms_pkg::ST_START);
	assign cyc_end = DEMAG_END & (st_reg == ffms_pkg::ST_RUN);

	// Over-voltage covers an open low-side divider too
	assign cmp.ov        = OVP_CMP;
	assign cmp.line_run  = line_smp_reg;
	assign cmp.line_stop = stop_smp_reg;
	// An over-current seen in the closing demag cycle still counts, so set wins
	assign cmp.oc        = oc_seen_reg | (demag_reg & OC_CMP);

	////////////////////////////////////////////////////////////////////////////
	// Consecutive-cycle qualifiers: ov, stop, oc share one module
	////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_qual
			ffms_qual_counter u_qual (
				.CORE_CLK (CORE_CLK),
				.NRST     (NRST),
				.clr      (clr_cnt),
				.cyc_end  (cyc_end),
				.cond     ((gi == 0) ? cmp.ov :
				           (gi == 1) ? (cmp.line_stop & line_ok_reg) : cmp.oc),
				.hit      (hits[gi])
			);
		end
	endgenerate

	// Window expired on first cycle without the sense minimum
	assign csmin_fail = first_reg & drv_reg & ~csmin_ok_reg
	                  & (csmin_cnt_reg >= 11'(CSMIN_CYCLES));

	assign ovl_trip = (ovl_cnt_reg >= 25'(OVL_CYCLES - 1)) & CCL_ACTIVE;

	// Gather fault causes
	always_comb begin
		cause_now          = '0;
		cause_now.ov       = hits[0];
		cause_now.line     = hits[1]
		                   | (cyc_end & (start_cnt_reg == (`FFMS_START_CYCLES - 2'h1))
		                      & ~line_ok_reg & ~cmp.line_run);
		cause_now.oc       = hits[2];
		cause_now.short_cs = csmin_fail;
		cause_now.otp      = OTP_CMP;
		cause_now.ovl      = ovl_trip;
	end
	assign fault_any = |cause_now;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next        = st_reg;
		drv_next       = drv_reg;
		start_cnt_next = start_cnt_reg;
		first_next     = first_reg;
		cause_next     = cause_reg;
		hs_hold_next   = hs_hold_reg;
		case (st_reg)
			ffms_pkg::ST_START: begin
				// Wait for supply to reach turn-on, nothing else
				drv_next = 1'b0;
				// A run cut by turn-off must not carry retry mode into the next start
				hs_hold_next = 1'b0;
				if (VDD_ON && !VDD_OFF) begin
					st_next        = ffms_pkg::ST_RUN;
					start_cnt_next = 2'h0;
					first_next     = 1'b1;
				end
			end
			ffms_pkg::ST_RUN, ffms_pkg::ST_WAIT: begin
				if (VDD_OFF) begin
					st_next  = ffms_pkg::ST_START;
					drv_next = 1'b0;
				end else if (fault_any) begin
					st_next    = ffms_pkg::ST_FAULT;
					drv_next   = 1'b0;
					cause_next = cause_now;
				end else if (hs_hold_reg && !first_reg && !drv_reg && !demag_reg) begin
					// Single on-time done, stop until supply collapses
					st_next  = ffms_pkg::ST_FAULT;
					drv_next = 1'b0;
				end else if (st_reg == ffms_pkg::ST_WAIT) begin
					// Next cycle brings back run bias
					if (CYCLE_START) begin
						st_next  = ffms_pkg::ST_RUN;
						drv_next = 1'b1;
					end
				end else begin
					if (CYCLE_START && !drv_reg && !demag_reg) begin
						drv_next = 1'b1;
					end else if (PEAK_REACHED && drv_reg) begin
						drv_next   = 1'b0;
						first_next = 1'b0;
						if (HS_OPEN) begin
							hs_hold_next = 1'b1;
						end
					end
					if (cyc_end) begin
						if (start_cnt_reg != `FFMS_START_CYCLES) begin
							start_cnt_next = start_cnt_reg + 2'h1;
						end
						// Wait only with peak below ceiling
						if (!PEAK_AT_MAX) begin
							st_next = ffms_pkg::ST_WAIT;
						end
					end
				end
			end
			ffms_pkg::ST_FAULT: begin
				drv_next = 1'b0;
				// Discharge to turn-off, then start again
				if (VDD_OFF) begin
					st_next      = ffms_pkg::ST_START;
					hs_hold_next = 1'b0;
				end
			end
			default: begin
				st_next  = ffms_pkg::ST_START;
				drv_next = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-cycle samplers and timers next state
	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		line_ok_next   = line_ok_reg;
		line_smp_next  = line_smp_reg;
		stop_smp_next  = stop_smp_reg;
		oc_seen_next   = oc_seen_reg;
		demag_next     = demag_reg;
		csmin_ok_next  = csmin_ok_reg;
		csmin_cnt_next = csmin_cnt_reg;
		ovl_cnt_next   = ovl_cnt_reg;
		if (clr_cnt) begin
			line_ok_next   = 1'b0;
			line_smp_next  = 1'b0;
			stop_smp_next  = 1'b0;
			oc_seen_next   = 1'b0;
			demag_next     = 1'b0;
			csmin_ok_next  = 1'b0;
			csmin_cnt_next = '0;
		end else begin
			// Line sense only valid while gate is on
			if (drv_reg) begin
				line_smp_next = LINE_RUN_CMP;
				stop_smp_next = LINE_STOP_CMP;
				if (LINE_RUN_CMP) begin
					line_ok_next = 1'b1;
				end
				if (csmin_cnt_reg != 11'h7ff) begin
					csmin_cnt_next = csmin_cnt_reg + 11'h1;
				end
				if (CSMIN_CMP) begin
					csmin_ok_next = 1'b1;
				end
			end
			if (PEAK_REACHED && drv_reg) begin
				demag_next = 1'b1;
			end
			// Over-current window: after blanking, before demag end
			if ((drv_reg && BLANK_DONE) || demag_reg) begin
				if (OC_CMP) begin
					oc_seen_next = 1'b1;
				end
			end
			if (cyc_end) begin
				demag_next   = 1'b0;
				oc_seen_next = 1'b0;
			end
		end
		// Overload timer runs only with CCL_ACTIVE in run or wait, start-up cycles included; otherwise it clears
		if (CCL_ACTIVE && (st_reg == ffms_pkg::ST_RUN || st_reg == ffms_pkg::ST_WAIT)) begin
			ovl_cnt_next = ovl_cnt_reg + 25'h1;
		end else begin
			ovl_cnt_next = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			st_reg        <= ffms_pkg::ST_START;
			drv_reg       <= 1'b0;
			start_cnt_reg <= 2'h0;
			first_reg     <= 1'b0;
			cause_reg     <= 6'h00;
			hs_hold_reg   <= 1'b0;
			line_ok_reg   <= 1'b0;
			line_smp_reg  <= 1'b0;
			stop_smp_reg  <= 1'b0;
			oc_seen_reg   <= 1'b0;
			demag_reg     <= 1'b0;
			csmin_ok_reg  <= 1'b0;
			csmin_cnt_reg <= 11'h000;
			ovl_cnt_reg   <= 25'h0000000;
		end else begin
			st_reg        <= st_next;
			drv_reg       <= drv_next;
			start_cnt_reg <= start_cnt_next;
			first_reg     <= first_next;
			cause_reg     <= cause_next;
			hs_hold_reg   <= hs_hold_next;
			line_ok_reg   <= line_ok_next;
			line_smp_reg  <= line_smp_next;
			stop_smp_reg  <= stop_smp_next;
			oc_seen_reg   <= oc_seen_next;
			demag_reg     <= demag_next;
			csmin_ok_reg  <= csmin_ok_next;
			csmin_cnt_reg <= csmin_cnt_next;
			ovl_cnt_reg   <= ovl_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////////////
	// Bias follows the state; fault bias holds until turn-off
	always_comb begin
		case (st_reg)
			ffms_pkg::ST_RUN:   BIAS_SEL = `FFMS_BIAS_RUN;
			ffms_pkg::ST_WAIT:  BIAS_SEL = `FFMS_BIAS_WAIT;
			ffms_pkg::ST_FAULT: BIAS_SEL = `FFMS_BIAS_FAULT;
			default:            BIAS_SEL = `FFMS_BIAS_START;
		endcase
	end

	// Start-up cycles run at the peak floor
	assign PEAK_SEL    = (start_cnt_reg == `FFMS_START_CYCLES) ? `FFMS_PEAK_LAW
	                                                            : `FFMS_PEAK_FLOOR;
	assign GATE_DRIVE  = drv_reg;
	assign STATE       = st_reg;
	assign FAULT_CAUSE = cause_reg;

endmodule : ffms_sequencer

/* verilog/ffms_defines.svh */
// Notes on behaviour
// - Over-voltage above threshold three cycles trips fault.
// - Over-voltage fault stops switching, starts fault cycle.
// - After fault discharge, restart only at turn-on.
// - Line current sampled only during gate on-time.
// - Line must exceed run level within three cycles.
// - Line below stop level three cycles trips.
// - Peak current control applied every switching cycle.
// - Over-current in sense window three cycles trips.
// - Open sense pin reads as over-current.
// - First cycle checks sense minimum within window.
// - Open high-side divider stops; single on-time retries.
// - Open low-side divider appears as over-voltage.
// - Over-temperature enters fault cycle, repeats while hot.
// - Below turn-on, switching stays disabled.
// - First three cycles limited to peak floor.
// - Overload held for timeout forces shutdown.
// - Overload dropping early resets the timer.
// - Peak at ceiling keeps run bias always.
// - Below ceiling, wait bias after demagnetization.
// - Supply below turn-off stops, selects start bias.
// - Fault selects fault bias until turn-off.
// - Fault and restart repeat while fault persists.
`ifndef FFMS_DEFINES_SVH
`define FFMS_DEFINES_SVH

// Consecutive-cycle qualification count
`define FFMS_QUAL_CYCLES   2'h3
// Start-up cycles held at the peak floor
`define FFMS_START_CYCLES  2'h3
// Clock rate in MHz
`define FFMS_CLK_MHZ       200
// Sense minimum check window in us, and its longest count in cycles
`define FFMS_CSMIN_US      5
`define FFMS_CSMIN_CYC     (`FFMS_CSMIN_US * `FFMS_CLK_MHZ)
// Overload timeout in ms, and its count in cycles
`define FFMS_OVL_MS        120
`define FFMS_OVL_CYC       (`FFMS_OVL_MS * 1000 * `FFMS_CLK_MHZ)
// Bias level codes
`define FFMS_BIAS_START    2'h0
`define FFMS_BIAS_RUN      2'h1
`define FFMS_BIAS_WAIT     2'h2
`define FFMS_BIAS_FAULT    2'h3
// Peak level codes
`define FFMS_PEAK_FLOOR    1'h0
`define FFMS_PEAK_LAW      1'h1

`endif

/* verilog/ffms_pkg.sv */
package ffms_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_START = 3'b000,
		ST_RUN   = 3'b001,
		ST_WAIT  = 3'b010,
		ST_FAULT = 3'b011
	} ffms_state_t;

	// Per-cycle comparator samples, held together
	typedef struct packed {
		logic ov;       // Sampled aux sense above over-voltage threshold
		logic line_run; // Line current above run threshold
		logic line_stop;// Line current below stop threshold
		logic oc;       // Sense above over-current level in window
	} ffms_cmp_t;

	// Fault cause flags
	typedef struct packed {
		logic ov;
		logic line;
		logic oc;
		logic short_cs;
		logic otp;
		logic ovl;
	} ffms_cause_t;

endpackage : ffms_pkg

/* verilog/ffms_qual_counter.sv */
`timescale 1ns/1ps
`include "ffms_defines.svh"

// Counts consecutive switching cycles with a condition met
module ffms_qual_counter (
	input  wire logic CORE_CLK,
	input  wire logic NRST,
	input  wire logic clr,      // Clear on start entry
	input  wire logic cyc_end,  // One pulse per switching cycle
	input  wire logic cond,     // Condition seen this cycle
	output logic      hit       // Qualified after three cycles
);

	logic [1:0] cnt_reg;  // Consecutive count
	logic [1:0] cnt_next; // Next count
	logic       hit_reg;  // Qualified flag
	logic       hit_next; // Next qualified flag

	// Next count: a missed cycle returns to zero
	always_comb begin
		cnt_next = cnt_reg;
		hit_next = hit_reg;
		if (clr) begin
			cnt_next = 2'h0;
			hit_next = 1'b0;
		end else if (cyc_end) begin
			if (!cond) begin
				cnt_next = 2'h0;
				hit_next = 1'b0;
			end else if (cnt_reg != `FFMS_QUAL_CYCLES) begin
				cnt_next = cnt_reg + 2'h1;
				hit_next = (cnt_reg == (`FFMS_QUAL_CYCLES - 2'h1));
			end
		end
	end

	// Register stage
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			cnt_reg <= 2'h0;
			hit_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			hit_reg <= hit_next;
		end
	end

	assign hit = hit_reg;

endmodule : ffms_qual_counter

/* sim/ffms_sequencer_asserts.sv */
`timescale 1ns/1ps
//////////////////////////////
// Port-level checks on the fault and mode sequencer
module ffms_seq_chk #(
	parameter int unsigned OVL_CYCLES   = 200, // Overload timeout count
	parameter int unsigned CSMIN_CYCLES = 8    // Sense minimum window
) (
	input wire logic       CORE_CLK,
	input wire logic       NRST,
	input wire logic       VDD_ON,
	input wire logic       VDD_OFF,
	input wire logic       CYCLE_START,
	input wire logic       PEAK_REACHED,
	input wire logic       DEMAG_END,
	input wire logic       OVP_CMP,
	input wire logic       OTP_CMP,
	input wire logic       PEAK_AT_MAX,
	input wire logic       GATE_DRIVE,
	input wire logic [1:0] BIAS_SEL,
	input wire logic [2:0] STATE,
	input wire logic [5:0] FAULT_CAUSE
);
	logic [1:0] ov_cnt; // Consecutive over-voltage cycles, saturates at 3
	logic       run;    // Switching states, where faults are taken
	assign run = STATE == ffms_pkg::ST_RUN || STATE == ffms_pkg::ST_WAIT;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// A missed cycle or a fresh start clears the count
	always_ff @(posedge CORE_CLK) begin
		if (!NRST || STATE == ffms_pkg::ST_START)
			ov_cnt <= 2'h0;
		else if (DEMAG_END)
			ov_cnt <= OVP_CMP ? ov_cnt + {1'h0, ov_cnt != 2'h3} : 2'h0;
	end
	//////////////////////////////
	a_ov_qualify: assert property (run && DEMAG_END && OVP_CMP && ov_cnt == 2'h2 && !VDD_OFF
		|-> ##[1:3] STATE == ffms_pkg::ST_FAULT) else $error("over-voltage not taken");
	a_ov_early: assert property ($rose(FAULT_CAUSE[5]) |-> ov_cnt == 2'h3)
		else $error("over-voltage fault too early");
	a_fault_quiet: assert property (STATE == ffms_pkg::ST_FAULT
		|-> !GATE_DRIVE && BIAS_SEL == 2'h3) else $error("fault state drives gate");
	a_off_start: assert property (VDD_OFF |=> STATE == ffms_pkg::ST_START
		&& BIAS_SEL == 2'h0 && !GATE_DRIVE) else $error("turn-off not obeyed");
	a_start_hold: assert property (STATE == ffms_pkg::ST_START && !VDD_ON
		|=> STATE == ffms_pkg::ST_START) else $error("left start early");
	a_start_quiet: assert property (STATE == ffms_pkg::ST_START
		&& $past(STATE) == ffms_pkg::ST_START |-> !GATE_DRIVE) else $error("gate in start");
	a_gate_cause: assert property ($rose(GATE_DRIVE) |-> $past(CYCLE_START)
		&& $past(STATE) != ffms_pkg::ST_START) else $error("gate rose uncalled");
	a_gate_fall: assert property (GATE_DRIVE && PEAK_REACHED |=> !GATE_DRIVE)
		else $error("gate held past peak");
	a_otp_fault: assert property (run && OTP_CMP && !VDD_OFF
		|-> ##[1:2] STATE == ffms_pkg::ST_FAULT) else $error("hot die not faulted");
	a_max_run: assert property (STATE == ffms_pkg::ST_RUN && PEAK_AT_MAX
		|=> STATE != ffms_pkg::ST_WAIT) else $error("wait at peak ceiling");
	a_run_bias: assert property (STATE == ffms_pkg::ST_RUN |-> BIAS_SEL == 2'h1)
		else $error("run bias wrong");
	a_wait_bias: assert property (STATE == ffms_pkg::ST_WAIT
		|-> BIAS_SEL == 2'h2 && !GATE_DRIVE) else $error("wait bias wrong");
	// Main scenarios reached
	c_fault: cover property (STATE == ffms_pkg::ST_FAULT);
	c_wait: cover property ($rose(STATE == ffms_pkg::ST_WAIT));
	c_gate: cover property ($rose(GATE_DRIVE));
endmodule : ffms_seq_chk

bind ffms_sequencer ffms_seq_chk #(
	.OVL_CYCLES(OVL_CYCLES), .CSMIN_CYCLES(CSMIN_CYCLES)
) u_chk (
	.CORE_CLK, .NRST, .VDD_ON, .VDD_OFF, .CYCLE_START, .PEAK_REACHED, .DEMAG_END,
	.OVP_CMP, .OTP_CMP, .PEAK_AT_MAX, .GATE_DRIVE, .BIAS_SEL, .STATE, .FAULT_CAUSE
);

/* sim/ffms_power_stage.sv */
`timescale 1ns/1ps
// Switch, transformer and sense network around the sequencer
module ffms_power_stage (
	input  wire logic clk,
	input  wire logic gate_drive,
	input  wire logic en,       // Control law asks for cycles
	input  wire logic slow,     // Long on-time
	input  wire logic line_ok,  // Bulk voltage adequate
	input  wire logic cs_short, // Sense pin shorted to ground
	input  wire logic cs_open,  // Sense pin left open
	output logic      cycle_start,
	output logic      peak_reached,
	output logic      demag_end,
	output logic      blank_done,
	output logic      line_run,
	output logic      line_stop,
	output logic      oc,
	output logic      csmin
);
	logic [1:0] ph_reg  = 2'h0; // 0 gap, 1 on-time, 2 demag
	logic [3:0] cnt_reg = 4'h0; // Cycles spent in this phase
	assign blank_done = gate_drive && cnt_reg != 4'h0;
	// Line current flows only while on; off-time shows the opposite level
	assign line_run  = gate_drive ? line_ok : !line_ok;
	assign line_stop = gate_drive ? !line_ok : line_ok;
	assign csmin     = gate_drive && !cs_short;
	assign oc        = cs_open;
	// Phase walk; a cut on-time drops back to idle with no demag
	always @(posedge clk) begin
		cycle_start <= 1'h0;
		peak_reached <= 1'h0;
		demag_end <= 1'h0;
		cnt_reg <= cnt_reg + 4'h1;
		case (ph_reg)
			2'h0: if (en && cnt_reg > 4'h3) begin
				cycle_start <= 1'h1;
				ph_reg <= 2'h1;
				cnt_reg <= 4'h0;
			end
			2'h1: if (gate_drive && cnt_reg > (slow ? 4'hb : 4'h1)) begin
				peak_reached <= 1'h1;
				ph_reg <= 2'h2;
				cnt_reg <= 4'h0;
			end else if (!gate_drive && cnt_reg > 4'h4) begin
				ph_reg <= 2'h0;
				cnt_reg <= 4'h0;
			end
			default: if (cnt_reg > 4'h3) begin
				demag_end <= 1'h1;
				ph_reg <= 2'h0;
				cnt_reg <= 4'h0;
			end
		endcase
	end
endmodule : ffms_power_stage

/* sim/test_ffms_sequencer.sv */
`timescale 1ns/1ps
module test_ffms_sequencer;
	logic       clk, nrst, vdd_on, vdd_off, ovp, otp, hs_open, ccl, pk_max;
	logic       en, slow, line_ok, cs_short, cs_open;
	logic       cyc_start, peak, demag, blank, line_run, line_stop, oc, csmin;
	logic       gate, peak_sel;
	logic [1:0] bias;
	logic [2:0] state;
	logic [5:0] cause;
	int         bad_count, checked;
	ffms_sequencer #(.OVL_CYCLES(200), .CSMIN_CYCLES(8)) uut (
		.CORE_CLK(clk), .NRST(nrst), .VDD_ON(vdd_on), .VDD_OFF(vdd_off),
		.CYCLE_START(cyc_start), .PEAK_REACHED(peak), .DEMAG_END(demag),
		.BLANK_DONE(blank), .OVP_CMP(ovp), .LINE_RUN_CMP(line_run),
		.LINE_STOP_CMP(line_stop), .OC_CMP(oc), .CSMIN_CMP(csmin), .OTP_CMP(otp),
		.HS_OPEN(hs_open), .CCL_ACTIVE(ccl), .PEAK_AT_MAX(pk_max), .GATE_DRIVE(gate),
		.BIAS_SEL(bias), .PEAK_SEL(peak_sel), .STATE(state), .FAULT_CAUSE(cause));
	ffms_power_stage stage (
		.clk(clk), .gate_drive(gate), .en(en), .slow(slow), .line_ok(line_ok),
		.cs_short(cs_short), .cs_open(cs_open), .cycle_start(cyc_start),
		.peak_reached(peak), .demag_end(demag), .blank_done(blank),
		.line_run(line_run), .line_stop(line_stop), .oc(oc), .csmin(csmin));
	always #2.5 clk = ~clk;
	//////////////////////////////
	task chk(input logic [5:0] seen, input logic [5:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task finish_test;
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	// Inputs move just after the edge
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Bounded wait for a state
	task wst(input logic [2:0] s, input int lim);
		for (int i = 0; i < lim && state !== s; i++)
			tick(1);
		chk(6'(state), 6'(s));
	endtask : wst
	// Bounded wait for n ends of demagnetization
	task cyc(input int n);
		int i;
		for (int k = 0; k < n; k++) begin
			i = 0;
			do begin
				@(posedge clk);
				i++;
			end while (demag !== 1'h1 && i < 200);
			chk(6'(demag), 6'h1);
		end
		#1;
	endtask : cyc
	// Supply collapses to turn-off, then recovers to turn-on
	task restart;
		vdd_off = 1;
		tick(2);
		chk(6'(state), 6'h0);
		vdd_off = 0;
		vdd_on = 1;
		wst(3'h1, 3);
		vdd_on = 0;
	endtask : restart
	task nofault;
		chk(6'(state === 3'h3), 6'h0);
	endtask : nofault
	//////////////////////////////
	task t_boot;
		tick(20);
		chk({1'h0, state, bias} | 6'(gate), 6'h0);
		vdd_on = 1;
		tick(1);
		vdd_on = 0;
		chk(6'(state), 6'h1);
		chk(6'(peak_sel), 6'h0);
		cyc(2);
		chk(6'(peak_sel), 6'h0);
		cyc(1);
		chk({1'h0, state, bias}, 6'h0a);
		tick(2);
		chk(6'(peak_sel), 6'h1);
		chk(cause, 6'h0);
		pk_max = 1;
		cyc(3);
		chk({1'h0, state, bias}, 6'h05);
		pk_max = 0;
		vdd_off = 1;
		tick(1);
		chk({1'h0, state, bias} | 6'(gate), 6'h0);
		vdd_off = 0;
	endtask : t_boot
	task t_ov;
		restart;
		ovp = 1;
		cyc(2);
		ovp = 0;
		cyc(1);
		ovp = 1;
		cyc(2);
		tick(3);
		nofault;
		cyc(1);
		wst(3'h3, 4);
		chk({3'h0, bias, gate}, 6'h06);
		chk(6'(cause[5]), 6'h1);
		tick(20);
		chk(6'(state), 6'h3);
		restart;
		cyc(3);
		wst(3'h3, 4);
		ovp = 0;
	endtask : t_ov
	task t_line;
		line_ok = 0;
		restart;
		cyc(2);
		nofault;
		cyc(1);
		wst(3'h3, 4);
		chk(6'(cause[4]), 6'h1);
		line_ok = 1;
		restart;
		cyc(4);
		line_ok = 0;
		cyc(2);
		nofault;
		cyc(1);
		wst(3'h3, 4);
		line_ok = 1;
	endtask : t_line
	task t_sense;
		cs_open = 1;
		restart;
		cyc(2);
		nofault;
		cyc(1);
		wst(3'h3, 4);
		chk(6'(cause[3]), 6'h1);
		cs_open = 0;
		cs_short = 1;
		slow = 1;
		restart;
		wst(3'h3, 30);
		chk(6'(cause[2]), 6'h1);
		cs_short = 0;
		restart;
		cyc(2);
		nofault;
		slow = 0;
	endtask : t_sense
	task t_hs_otp;
		hs_open = 1;
		restart;
		wst(3'h3, 40);
		restart;
		wst(3'h3, 40);
		hs_open = 0;
		restart;
		cyc(4);
		otp = 1;
		wst(3'h3, 3);
		chk(6'(cause[1]), 6'h1);
		restart;
		wst(3'h3, 3);
		otp = 0;
	endtask : t_hs_otp
	task t_ovl;
		restart;
		cyc(4);
		ccl = 1;
		tick(150);
		ccl = 0;
		tick(2);
		ccl = 1;
		tick(150);
		nofault;
		tick(50);
		wst(3'h3, 20);
		chk(6'(cause[0]), 6'h1);
		ccl = 0;
	endtask : t_ovl
	//////////////////////////////
	initial begin
		{clk, nrst, vdd_on, vdd_off, ovp, otp, hs_open, ccl, pk_max} = '0;
		{slow, cs_short, cs_open} = '0;
		{en, line_ok} = 2'h3;
		bad_count = 0;
		checked = 0;
		tick(8);
		nrst = 1;
		t_boot;
		t_ov;
		t_line;
		t_sense;
		t_hs_otp;
		t_ovl;
		finish_test;
	end
	// Cuts a hang well past the expected run length
	initial begin
		#250000;
		bad_count++;
		finish_test;
	end
endmodule : test_ffms_sequencer
